//--- include/adc_port_pkg.sv
// Package: shared constants and types for the sampling converter port and its capture side
`default_nettype none
package adc_port_pkg;
  // ************************************************************
  // Word and pipeline
  // ************************************************************
  localparam int unsigned SAMPLE_WIDTH   = 10;
  localparam int unsigned LATENCY_CYCLES = 5;
  localparam int unsigned FIFO_DEPTH     = 16;
  localparam int unsigned TAG_WIDTH      = 16;

  // ************************************************************
  // Pin levels after reset and when left open
  // ************************************************************
  localparam logic OPEN_OUTPUT_DISABLE = 1'h0;
  localparam logic OPEN_SPAN_SELECT    = 1'h1;
  localparam logic OPEN_REF_SELECT     = 1'h1;
  localparam logic SPAN_2V             = 1'h1;
  localparam logic SPAN_1V             = 1'h0;
  localparam logic REF_EXTERNAL        = 1'h1;
  localparam logic REF_INTERNAL        = 1'h0;

  // ************************************************************
  // Capture control registers, byte offsets on Wishbone
  // ************************************************************
  localparam logic [3:0] REG_CONTROL   = 4'h0;
  localparam logic [3:0] REG_STATUS    = 4'h4;
  localparam logic [3:0] REG_SAMPLE    = 4'h8;
  localparam logic [3:0] REG_DROPPED   = 4'hC;
  localparam int unsigned CTL_DISABLE  = 0;
  localparam int unsigned CTL_SLEEP    = 1;
  localparam int unsigned CTL_SPAN     = 2;
  localparam int unsigned CTL_REF      = 3;
  localparam int unsigned CTL_CAPTURE  = 4;
  localparam logic [4:0] CONTROL_RESET = 5'h0C;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

  // ************************************************************
  // Converter model modes
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_RUN   = 2'b01,
    MODE_SLEEP = 2'b10
  } conv_mode_e;
endpackage
`default_nettype wire

//--- include/adc_port_if.sv
// Interface: parallel sample bus and static control pins between converter and capture logic
`timescale 1ns/100ps
`default_nettype none
interface adc_port_if;
  logic [9:0] data_out;
  logic [9:0] data_oe_n;
  logic       output_disable;
  logic       sleep_request;
  logic       span_select;
  logic       ref_source_select;
  logic [9:0] data_wire;

  // ************************************************************
  // Wire resolution: float reads as unknown-free zero, pull-ups and pull-down folded in by ends
  // ************************************************************
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      data_wire[i] = data_oe_n[i] ? 1'b0 : data_out[i];
    end
  end

  modport converter (
    output data_out,
    output data_oe_n,
    input  output_disable,
    input  sleep_request,
    input  span_select,
    input  ref_source_select
  );

  modport capture (
    input  data_wire,
    input  data_oe_n,
    output output_disable,
    output sleep_request,
    output span_select,
    output ref_source_select
  );
endinterface
`default_nettype wire

//--- rtl/sample_fifo.sv
// Module: flip-flop FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module sample_fifo #(
  parameter int unsigned WIDTH = 26,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
    $error("DEPTH must be a power of two");
  end
  if (WIDTH < 1) begin
    $error("WIDTH must be positive");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 count;
  } fifo_s;

  fifo_s state_reg;
  fifo_s state_next;
  logic  push;
  logic  pop;

  assign in_ready_o  = (state_reg.count != (AW+1)'(DEPTH));
  assign out_valid_o = (state_reg.count != '0);
  assign out_data_o  = state_reg.mem[state_reg.rd];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    state_next = state_reg;
    if (push) begin
      state_next.mem[state_reg.wr] = in_data_i;
      state_next.wr = state_reg.wr + AW'(1);
    end
    if (pop) begin
      state_next.rd = state_reg.rd + AW'(1);
    end
    if (push && !pop) begin
      state_next.count = state_reg.count + (AW+1)'(1);
    end else if (pop && !push) begin
      state_next.count = state_reg.count - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule
`default_nettype wire

//--- rtl/adc_converter.sv
// Module: digital port of the pipelined converter, sample pipeline and pin handling
// ************************************************************
// Summary of operation
// - New word valid on rising clock edge
// - Sample appears exactly five clocks later
// - Output disable high floats all data pins
// - Open output disable means driven outputs
// - Sleep request high powers converter down
// - Span select high 2V, low 1V
// - Reference select high external, low internal
// - Ten bits, bit 1 MSB D9
// - Open span/reference pins: 2V, external
// ************************************************************
`timescale 1ns/100ps
`default_nettype none
module adc_converter #(
  parameter int unsigned WIDTH   = 10,
  parameter int unsigned LATENCY = 5
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  adc_port_if.converter         port,
  input  wire logic [WIDTH-1:0] sample_i,
  input  wire logic             disable_open_i,
  input  wire logic             span_open_i,
  input  wire logic             ref_open_i,
  output logic                  powered_down_o,
  output logic                  span_2v_o,
  output logic                  ref_external_o
);
  if (WIDTH != adc_port_pkg::SAMPLE_WIDTH) begin
    $error("WIDTH must be 10");
  end
  if (LATENCY < 1) begin
    $error("LATENCY must be at least one");
  end

  // Stage 0 holds the sample taken at an edge; LATENCY more edges carry it to the pins
  typedef struct packed {
    logic [LATENCY:0][WIDTH-1:0]   pipe;
    adc_port_pkg::conv_mode_e      mode;
    logic                          span;
    logic                          refsel;
  } conv_s;

  conv_s state_reg;
  conv_s state_next;
  logic  disable_eff;
  logic  span_eff;
  logic  ref_eff;

  // ************************************************************
  // Open pins resolve to their internal pull levels
  // ************************************************************
  assign disable_eff = disable_open_i ? adc_port_pkg::OPEN_OUTPUT_DISABLE
                                      : port.output_disable;
  assign span_eff    = span_open_i ? adc_port_pkg::OPEN_SPAN_SELECT : port.span_select;
  assign ref_eff     = ref_open_i ? adc_port_pkg::OPEN_REF_SELECT
                                  : port.ref_source_select;

  always_comb begin
    state_next        = state_reg;
    state_next.span   = span_eff;
    state_next.refsel = ref_eff;
    unique case (state_reg.mode)
      adc_port_pkg::MODE_RUN: begin
        if (port.sleep_request) begin
          state_next.mode = adc_port_pkg::MODE_SLEEP;
        end
      end
      adc_port_pkg::MODE_SLEEP: begin
        if (!port.sleep_request) begin
          state_next.mode = adc_port_pkg::MODE_RUN;
        end
      end
      default: state_next.mode = adc_port_pkg::MODE_RUN;
    endcase
    // Asleep the pipeline holds its last words; no new samples enter
    if (state_next.mode == adc_port_pkg::MODE_RUN) begin
      state_next.pipe[0] = sample_i;
      for (int i = 1; i <= LATENCY; i++) begin
        state_next.pipe[i] = state_reg.pipe[i-1];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg        <= '0;
      state_reg.mode   <= adc_port_pkg::MODE_RUN;
      state_reg.span   <= adc_port_pkg::OPEN_SPAN_SELECT;
      state_reg.refsel <= adc_port_pkg::OPEN_REF_SELECT;
    end else begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // Pins: index 9 is bit 1 (D9, MSB), index 0 is bit 10 (D0, LSB)
  // ************************************************************
  assign port.data_out       = state_reg.pipe[LATENCY];
  assign port.data_oe_n      = {WIDTH{disable_eff}};
  assign powered_down_o      = (state_reg.mode == adc_port_pkg::MODE_SLEEP);
  assign span_2v_o           = (state_reg.span == adc_port_pkg::SPAN_2V);
  assign ref_external_o      = (state_reg.refsel == adc_port_pkg::REF_EXTERNAL);
endmodule
`default_nettype wire

//--- rtl/adc_capture.sv
// Module: capture logic with Wishbone control registers and a sample FIFO
//
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module adc_capture #(
  parameter int unsigned WIDTH   = 10,
  parameter int unsigned LATENCY = 5,
  parameter int unsigned DEPTH   = 16
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  adc_port_if.capture      port,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o
);
  localparam int unsigned TW = adc_port_pkg::TAG_WIDTH;

  if (WIDTH != adc_port_pkg::SAMPLE_WIDTH) begin
    $error("WIDTH must be 10");
  end
  if (LATENCY < 1 || LATENCY > 8) begin
    $error("LATENCY out of range");
  end

  typedef struct packed {
    logic [WIDTH-1:0] sync1;
    logic [WIDTH-1:0] sync2;
    logic [TW-1:0]    clk_count;
    logic [7:0]       warm;
    logic [4:0]       control;
    logic [15:0]      dropped;
    logic             ack;
    logic [31:0]      rdata;
  } cap_s;

  cap_s               state_reg;
  cap_s               state_next;
  logic [WIDTH+TW-1:0] fifo_out;
  logic               fifo_valid;
  logic               fifo_ready;
  logic               push_valid;
  logic               pop;
  logic               req;
  logic [TW-1:0]      tag;

  // Pins are driven straight from the control register
  assign port.output_disable    = state_reg.control[adc_port_pkg::CTL_DISABLE];
  assign port.sleep_request     = state_reg.control[adc_port_pkg::CTL_SLEEP];
  assign port.span_select       = state_reg.control[adc_port_pkg::CTL_SPAN];
  assign port.ref_source_select = state_reg.control[adc_port_pkg::CTL_REF];

  // Words count only once the converter has woken, loaded stage 0, refilled its
  // pipeline and passed both sync stages; earlier words are stale or floated
  assign push_valid = state_reg.control[adc_port_pkg::CTL_CAPTURE]
                      && !state_reg.control[adc_port_pkg::CTL_SLEEP]
                      && !state_reg.control[adc_port_pkg::CTL_DISABLE]
                      && (state_reg.warm >= 8'(LATENCY + 3));
  // Word seen now was sampled LATENCY clocks before it left the pins, two before this
  assign tag = state_reg.clk_count - TW'(LATENCY + 2);

  assign req = wb_cyc_i && wb_stb_i && !state_reg.ack;
  assign pop = req && !wb_we_i && (wb_adr_i == adc_port_pkg::REG_SAMPLE) && fifo_valid;

  sample_fifo #(
    .WIDTH (WIDTH + TW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_data_i   ({tag, state_reg.sync2}),
    .in_valid_i  (push_valid),
    .in_ready_o  (fifo_ready),
    .out_data_o  (fifo_out),
    .out_valid_o (fifo_valid),
    .out_ready_i (pop)
  );

  always_comb begin
    state_next           = state_reg;
    state_next.sync1     = port.data_wire;
    state_next.sync2     = state_reg.sync1;
    state_next.clk_count = state_reg.clk_count + TW'(1);
    state_next.ack       = req;
    if (push_valid && !fifo_ready && state_reg.dropped != 16'hFFFF) begin
      state_next.dropped = state_reg.dropped + 16'h0001;
    end
    if (state_reg.control[adc_port_pkg::CTL_CAPTURE]
        && !state_reg.control[adc_port_pkg::CTL_SLEEP]
        && !state_reg.control[adc_port_pkg::CTL_DISABLE]) begin
      if (state_reg.warm != 8'hFF) begin
        state_next.warm = state_reg.warm + 8'h01;
      end
    end else begin
      state_next.warm = 8'h00;
    end
    state_next.rdata = adc_port_pkg::UNMAPPED_READ;
    if (req) begin
      unique case (wb_adr_i)
        adc_port_pkg::REG_CONTROL: begin
          state_next.rdata = {27'h0, state_reg.control};
          if (wb_we_i && wb_sel_i[0]) begin
            state_next.control = wb_dat_i[4:0];
            if (wb_dat_i[adc_port_pkg::CTL_CAPTURE]
                != state_reg.control[adc_port_pkg::CTL_CAPTURE]) begin
              state_next.warm = 8'h00;
            end
          end
        end
        adc_port_pkg::REG_STATUS: begin
          state_next.rdata = {30'h0, !fifo_ready, fifo_valid};
        end
        adc_port_pkg::REG_SAMPLE: begin
          state_next.rdata = {fifo_valid, 5'h0, fifo_out};
        end
        adc_port_pkg::REG_DROPPED: begin
          state_next.rdata = {16'h0, state_reg.dropped};
          if (wb_we_i) begin
            // A drop in the same cycle survives the clear
            state_next.dropped = (push_valid && !fifo_ready) ? 16'h0001 : 16'h0000;
          end
        end
        default: state_next.rdata = adc_port_pkg::UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg         <= '0;
      state_reg.control <= adc_port_pkg::CONTROL_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign wb_ack_o = state_reg.ack;
  assign wb_dat_o = state_reg.rdata;
endmodule
`default_nettype wire

//--- tb/adc_port_sva.sv
// Checker: assertions on the sample bus and static control pins between the two ends
`timescale 1ns/100ps
`default_nettype none
module adc_port_sva (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic [9:0] data_out,
  input wire logic [9:0] data_oe_n,
  input wire logic       output_disable,
  input wire logic       sleep_request,
  input wire logic       span_select,
  input wire logic       ref_source_select,
  input wire logic [9:0] data_wire,
  input wire logic       disable_open
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_oe_tracks_disable: assert property (
    data_oe_n == {10{output_disable && !disable_open}})
    else $error("Data enables disagree with disable pin");
  a_float_reads_zero: assert property (
    output_disable && !disable_open |-> data_wire == 10'h000)
    else $error("Data bus driven while disabled");
  a_drive_reaches_wire: assert property (
    !output_disable |-> data_wire == data_out) else $error("Bus does not carry driven word");
  a_disable_recovers: assert property (
    $fell(output_disable) |-> ##[0:1] data_oe_n == 10'h000) else $error("Bus not driven again");
  a_sleep_freezes_data: assert property (
    sleep_request && $past(sleep_request) |=> $stable(data_out)) else $error("Word moved asleep");
  a_sleep_wire_hold: assert property (
    sleep_request && $past(sleep_request) && !output_disable
    |=> output_disable || $stable(data_wire)) else $error("Bus moved while asleep");
  a_reset_pin_levels: assert property (
    $fell(rst_i) |-> !output_disable && !sleep_request && span_select && ref_source_select)
    else $error("Control pins wrong after reset");
  a_reset_data_clear: assert property (
    $fell(rst_i) |-> data_out == 10'h000) else $error("Pipeline not cleared by reset");
endmodule
`default_nettype wire

//--- tb/pipelined_adc_digital_port_tb_top.sv
// Testbench: converter and capture ends joined, driven over Wishbone and the sample input
`timescale 1ns/100ps
`default_nettype none
module pipelined_adc_digital_port_tb_top;
  logic        clk_i;
  logic        rst_i;
  logic [9:0]  sample_i = 10'h000;
  logic [2:0]  open_pins;
  logic [3:0]  wb_adr;
  logic [31:0] wb_dat;
  logic        wb_we;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_ack_o;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic [31:0] prev;
  logic        powered_down_o;
  logic        span_2v_o;
  logic        ref_external_o;
  logic [9:0]  hist [0:5];
  logic [9:0]  held;
  int          n_fail;
  int          checks_done;
  int          cycles;
  int          run_cnt;

  adc_port_if ifc ();
  adc_converter u_adc_converter (.clk_i(clk_i), .rst_i(rst_i), .port(ifc.converter),
    .sample_i(sample_i), .disable_open_i(open_pins[2]), .span_open_i(open_pins[0]),
    .ref_open_i(open_pins[1]), .powered_down_o(powered_down_o), .span_2v_o(span_2v_o),
    .ref_external_o(ref_external_o));
  adc_capture u_adc_capture (.clk_i(clk_i), .rst_i(rst_i), .port(ifc.capture),
    .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_sel_i(4'hF),
    .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_ack_o(wb_ack_o));
  adc_port_sva u_adc_port_sva (.clk_i(clk_i), .rst_i(rst_i), .data_out(ifc.data_out),
    .data_oe_n(ifc.data_oe_n), .output_disable(ifc.output_disable),
    .sleep_request(ifc.sleep_request), .span_select(ifc.span_select),
    .ref_source_select(ifc.ref_source_select), .data_wire(ifc.data_wire),
    .disable_open(open_pins[2]));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Classic single cycle; holds everything until ack is sampled, then one idle cycle
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    wb_adr <= a;
    wb_we  <= w;
    wb_dat <= d;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask

  // ************************************************************
  // Sample ramp, history and timeout
  // ************************************************************
  always @(posedge clk_i) begin
    sample_i <= sample_i + 10'h001;
    hist[0] <= sample_i;
    for (int i = 1; i < 6; i++) hist[i] <= hist[i-1];
    run_cnt <= (rst_i || ifc.sleep_request) ? 0 : run_cnt + 1;
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // Margin of 8 covers the six edges the pipeline takes to refill after sleep or reset
  always @(negedge clk_i) if (run_cnt >= 8) chk(ifc.data_out, hist[5]);

  initial begin
    rst_i = 1'b1;
    open_pins = 3'b000;
    {wb_adr, wb_dat, wb_we, wb_cyc, wb_stb} = '0;
    n_fail = 0;
    checks_done = 0;
    cycles = 0;
    run_cnt = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(adc_port_pkg::REG_CONTROL, 1'b0, 0); chk(rd, 32'h0000000C);
    wb(adc_port_pkg::REG_STATUS, 1'b0, 0); chk(rd, 32'h00000000);
    wb(4'h2, 1'b1, 32'hFFFFFFFF);
    wb(4'h2, 1'b0, 0); chk(rd, 32'h00000000);
    wb(adc_port_pkg::REG_CONTROL, 1'b0, 0); chk(rd, 32'h0000000C);
    for (int i = 0; i < 4; i++) begin
      wb(adc_port_pkg::REG_CONTROL, 1'b1, i << 2);
      repeat (3) @(posedge clk_i);
      chk(span_2v_o, i[0]);
      chk(ref_external_o, i[1]);
    end
    // Disable asked for but its pin left open: the pull-down keeps the bus driven
    wb(adc_port_pkg::REG_CONTROL, 1'b1, 32'h00000001);
    open_pins <= 3'b111;
    repeat (3) @(posedge clk_i);
    chk(span_2v_o, 1);
    chk(ref_external_o, 1);
    chk(ifc.data_oe_n, 10'h000);
    open_pins <= 3'b000;
    wb(adc_port_pkg::REG_CONTROL, 1'b1, 32'h0000000D);
    repeat (2) @(posedge clk_i);
    chk(ifc.data_oe_n, 10'h3FF);
    chk(ifc.data_wire, 10'h000);
    wb(adc_port_pkg::REG_CONTROL, 1'b1, 32'h0000000E);
    repeat (3) @(posedge clk_i);
    chk(powered_down_o, 1);
    held = ifc.data_out;
    repeat (6) @(posedge clk_i);
    chk(ifc.data_out, held);
    wb(adc_port_pkg::REG_CONTROL, 1'b1, 32'h0000001C);
    repeat (40) @(posedge clk_i);
    chk(powered_down_o, 0);
    wb(adc_port_pkg::REG_CONTROL, 1'b1, 32'h0000000C);
    wb(adc_port_pkg::REG_STATUS, 1'b0, 0); chk(rd, 32'h00000003);
    for (int i = 0; i < 16; i++) begin
      wb(adc_port_pkg::REG_SAMPLE, 1'b0, 0);
      chk(rd[31], 1);
      // Ramp holds the edge count minus one; the tag counts edges after the 16 reset edges
      chk(10'(rd[9:0] - rd[19:10]), 10'h00F);
      if (i > 0) begin
        chk(rd[9:0], 10'(prev[9:0] + 10'h001));
      end
      prev = rd;
    end
    wb(adc_port_pkg::REG_STATUS, 1'b0, 0); chk(rd, 32'h00000000);
    wb(adc_port_pkg::REG_SAMPLE, 1'b0, 0); chk(rd[31], 0);
    wb(adc_port_pkg::REG_DROPPED, 1'b0, 0); chk(rd != 0, 1);
    wb(adc_port_pkg::REG_DROPPED, 1'b1, 0);
    wb(adc_port_pkg::REG_DROPPED, 1'b0, 0); chk(rd, 32'h00000000);
    repeat (2) @(posedge clk_i);
    report_and_stop();
  end
endmodule
`default_nettype wire
